// [hdl/cte_pkg.sv]
// Purpose: Constants and types shared by the transmit cancel / event FIFO / debug DMA block
// Assumes: Classic Wishbone slave with 32-bit data and byte address, 10 MHz clock
// Notes:   Register offsets are byte addresses; every register is one aligned word
package cte_pkg;
    localparam int ADR_W = 9;
    localparam int NBUF = 32;
    localparam int EV_MAX = 32;
    localparam int RX_IDX_W = 7;

    // Register byte offsets
    localparam logic [ADR_W-1:0] OFS_BUF_CONFIG = 9'h000;
    localparam logic [ADR_W-1:0] OFS_ADD_REQUEST = 9'h004;
    localparam logic [ADR_W-1:0] OFS_REQUEST_PENDING = 9'h008;
    localparam logic [ADR_W-1:0] OFS_CANCEL_REQUEST = 9'h00c;
    localparam logic [ADR_W-1:0] OFS_OCCURRED = 9'h010;
    localparam logic [ADR_W-1:0] OFS_CANCEL_FINISHED = 9'h014;
    localparam logic [ADR_W-1:0] OFS_EV_CONFIG = 9'h018;
    localparam logic [ADR_W-1:0] OFS_EV_STATUS = 9'h01c;
    localparam logic [ADR_W-1:0] OFS_EV_ACK = 9'h020;
    localparam logic [ADR_W-1:0] OFS_RX0_ACK = 9'h024;
    localparam logic [ADR_W-1:0] OFS_RX1_ACK = 9'h028;
    localparam logic [ADR_W-1:0] OFS_RX_CONFIG = 9'h02c;
    localparam logic [ADR_W-1:0] OFS_RX_STATUS = 9'h030;
    localparam logic [ADR_W-1:0] OFS_FLAGS = 9'h034;
    localparam logic [ADR_W-1:0] OFS_DEBUG_STATUS = 9'h038;
    // Per-buffer tables: identifier at 0x080 + 4n, marker at 0x100 + 4n
    localparam logic [1:0] REGION_ID = 2'h1;
    localparam logic [1:0] REGION_MARKER = 2'h2;

    // Field positions
    localparam int CFG_DED_LSB = 0;
    localparam int CFG_QUEUE_LSB = 8;
    localparam int EVC_START_LSB = 0;
    localparam int EVC_SIZE_LSB = 16;
    localparam int EVC_WM_LSB = 24;
    localparam int EVS_FILL_LSB = 0;
    localparam int EVS_GET_LSB = 8;
    localparam int EVS_PUT_LSB = 16;
    localparam int EVS_FULL_BIT = 24;
    localparam int RXC_SIZE1_LSB = 8;
    localparam int RXS_FILL0_LSB = 8;
    localparam int RXS_GET1_LSB = 16;
    localparam int RXS_FILL1_LSB = 24;
    localparam int FLG_FULL_BIT = 0;
    localparam int FLG_LOST_BIT = 1;
    localparam int FLG_WM_BIT = 2;

    // Reset values
    localparam logic [5:0] RST_COUNT = 6'h00;
    localparam logic [15:0] RST_EV_START = 16'h0000;

    typedef enum logic [0:0] {TX_IDLE, TX_BUSY} cte_tx_state_t;
    // Idle must encode as 00
    typedef enum logic [1:0] {DBG_IDLE, DBG_GOT_A, DBG_GOT_AB, DBG_LOCKED} cte_dbg_state_t;
    localparam logic [1:0] DBG_FRAME_A = 2'h1;
    localparam logic [1:0] DBG_FRAME_B = 2'h2;
    localparam logic [1:0] DBG_FRAME_C = 2'h3;
endpackage

// [hdl/cte_top.sv]
// Purpose: Transmit handler with cancellation, transmit event FIFO, FIFO acknowledge
//          indices and debug-frame DMA handshake of a CAN controller
// Assumes: Protocol engine, receive path and DMA controller run on clk_i
// Notes:   Event elements are written as two message RAM words, one per cycle
//
// The address map and register access over Wishbone are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module cte_top
    import cte_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Protocol engine
    output logic tx_start_o,
    output logic [4:0] tx_buffer_o,
    output logic [28:0] tx_id_o,
    input wire logic tx_done_i,
    input wire logic tx_ok_i,
    input wire logic [15:0] timestamp_i,
    // Message RAM write port for event elements
    output logic ram_we_o,
    output logic [15:0] ram_addr_o,
    output logic [31:0] ram_wdata_o,
    // Receive FIFO put indices
    input wire logic [RX_IDX_W-1:0] rx_fifo0_put_i,
    input wire logic [RX_IDX_W-1:0] rx_fifo1_put_i,
    // Debug frames and DMA
    input wire logic debug_frame_valid_i,
    input wire logic [1:0] debug_frame_sel_i,
    output logic debug_lock_o,
    output logic dma_req_o,
    input wire logic dma_ack_i
);
    typedef struct packed {
        logic [31:0] wb_dat;
        logic wb_ack;
        logic [5:0] dedicated_buffer_count;
        logic [5:0] queue_buffer_count;
        logic [NBUF-1:0][28:0] msg_id;
        logic [NBUF-1:0][7:0] marker;
        logic [NBUF-1:0] tx_request_pending;
        logic [NBUF-1:0] tx_occurred;
        logic [NBUF-1:0] tx_cancel_finished;
        cte_tx_state_t tx_st;
        logic cancel_armed;
        logic tx_start;
        logic [4:0] tx_buf;
        logic [28:0] tx_id;
        logic [15:0] event_fifo_start_address;
        logic [5:0] ev_size;
        logic [5:0] event_fifo_watermark_level;
        logic [4:0] event_fifo_get_index;
        logic [4:0] ev_put;
        logic [5:0] ev_fill;
        logic event_fifo_full_flag;
        logic event_fifo_lost_flag;
        logic event_fifo_watermark_flag;
        logic ev_second;
        logic [31:0] ev_word1;
        logic ram_we;
        logic [15:0] ram_addr;
        logic [31:0] ram_wdata;
        logic [RX_IDX_W-1:0] rx0_size;
        logic [RX_IDX_W-1:0] rx1_size;
        logic [RX_IDX_W-1:0] rx0_get;
        logic [RX_IDX_W-1:0] rx1_get;
        cte_dbg_state_t debug_frame_state;
        logic dma_req;
    } cte_state_t;

    cte_state_t q;
    cte_state_t d;
    logic [31:0] mask;
    logic [31:0] wdat;
    logic wr;
    logic rd;
    logic [NBUF-1:0] add_bits;
    logic [NBUF-1:0] cancel_bits;
    logic [6:0] active_total;
    logic best_found;
    logic [4:0] best_idx;
    logic [28:0] best_id;
    logic [5:0] ev_depth;
    logic [31:0] rdat;

    // Index after v in a ring of the given size; unchecked by design
    function automatic logic [RX_IDX_W-1:0] ring_next(input logic [RX_IDX_W-1:0] v,
                                                       input logic [RX_IDX_W-1:0] size);
        logic [RX_IDX_W:0] n;
        n = {1'b0, v} + 8'h01;
        ring_next = (n >= {1'b0, size}) ? 7'h00 : n[RX_IDX_W-1:0];
    endfunction

    function automatic logic [RX_IDX_W-1:0] ring_fill(input logic [RX_IDX_W-1:0] put,
                                                       input logic [RX_IDX_W-1:0] get,
                                                       input logic [RX_IDX_W-1:0] size);
        ring_fill = (put >= get) ? 7'(put - get) : 7'(put + size - get);
    endfunction

    always_comb
    begin
        d = q;
        d.wb_ack = 1'b0;
        d.tx_start = 1'b0;
        d.ram_we = 1'b0;
        d.wb_dat = 32'h0000_0000;
        mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        wdat = wb_dat_i & mask;
        // Request taken on the edge that raises ack; ack lasts one cycle
        wr = wb_cyc_i & wb_stb_i & wb_we_i & ~q.wb_ack;
        rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~q.wb_ack;
        add_bits = (wr && wb_adr_i == OFS_ADD_REQUEST) ? wdat : 32'h0000_0000;
        cancel_bits = (wr && wb_adr_i == OFS_CANCEL_REQUEST) ? wdat : 32'h0000_0000;
        active_total = 7'({1'b0, q.dedicated_buffer_count} + {1'b0, q.queue_buffer_count});
        // Depth above the maximum is clamped
        ev_depth = (q.ev_size > 6'(EV_MAX)) ? 6'(EV_MAX) : q.ev_size;

        // Register reads
        rdat = 32'h0000_0000;
        unique case (wb_adr_i)
            OFS_BUF_CONFIG: rdat = {18'h0, q.queue_buffer_count, 2'h0, q.dedicated_buffer_count};
            OFS_REQUEST_PENDING: rdat = q.tx_request_pending;
            OFS_OCCURRED: rdat = q.tx_occurred;
            OFS_CANCEL_FINISHED: rdat = q.tx_cancel_finished;
            OFS_EV_CONFIG: rdat = {2'h0, q.event_fifo_watermark_level, 2'h0, q.ev_size,
                                   q.event_fifo_start_address};
            OFS_EV_STATUS: rdat = {7'h0, q.ev_fill == ev_depth && ev_depth != 6'h00, 3'h0, q.ev_put,
                                   3'h0, q.event_fifo_get_index, 2'h0, q.ev_fill};
            OFS_RX_CONFIG: rdat = {17'h0, q.rx1_size, 1'b0, q.rx0_size};
            OFS_RX_STATUS: rdat = {1'b0, ring_fill(rx_fifo1_put_i, q.rx1_get, q.rx1_size),
                                   1'b0, q.rx1_get,
                                   1'b0, ring_fill(rx_fifo0_put_i, q.rx0_get, q.rx0_size),
                                   1'b0, q.rx0_get};
            OFS_FLAGS: rdat = {29'h0, q.event_fifo_watermark_flag, q.event_fifo_lost_flag,
                               q.event_fifo_full_flag};
            OFS_DEBUG_STATUS: rdat = {29'h0, q.dma_req, q.debug_frame_state};
            default:
            begin
                if (wb_adr_i[8:7] == REGION_ID)
                    rdat = {3'h0, q.msg_id[wb_adr_i[6:2]]};
                else if (wb_adr_i[8:7] == REGION_MARKER)
                    rdat = {24'h0, q.marker[wb_adr_i[6:2]]};
            end
        endcase
        if (wr || rd)
        begin
            d.wb_ack = 1'b1;
            d.wb_dat = rd ? rdat : 32'h0000_0000;
        end

        // Register writes
        if (wr)
        begin
            unique case (wb_adr_i)
                OFS_BUF_CONFIG:
                begin
                    if (wb_sel_i[0])
                        d.dedicated_buffer_count = wb_dat_i[CFG_DED_LSB +: 6];
                    if (wb_sel_i[1])
                        d.queue_buffer_count = wb_dat_i[CFG_QUEUE_LSB +: 6];
                end
                OFS_EV_CONFIG:
                begin
                    if (wb_sel_i[0])
                        d.event_fifo_start_address[7:0] = wb_dat_i[EVC_START_LSB +: 8];
                    if (wb_sel_i[1])
                        d.event_fifo_start_address[15:8] = wb_dat_i[EVC_START_LSB + 8 +: 8];
                    if (wb_sel_i[2])
                        d.ev_size = wb_dat_i[EVC_SIZE_LSB +: 6];
                    if (wb_sel_i[3])
                        d.event_fifo_watermark_level = wb_dat_i[EVC_WM_LSB +: 6];
                end
                OFS_EV_ACK:
                begin
                    d.event_fifo_get_index = 5'(ring_next(7'(wdat[4:0]), 7'(ev_depth)));
                    d.ev_fill = 6'(ring_fill(7'(q.ev_put), 7'(d.event_fifo_get_index), 7'(ev_depth)));
                end
                OFS_RX0_ACK: d.rx0_get = ring_next(wdat[RX_IDX_W-1:0], q.rx0_size);
                OFS_RX1_ACK: d.rx1_get = ring_next(wdat[RX_IDX_W-1:0], q.rx1_size);
                OFS_RX_CONFIG:
                begin
                    if (wb_sel_i[0])
                        d.rx0_size = wb_dat_i[RX_IDX_W-1:0];
                    if (wb_sel_i[1])
                        d.rx1_size = wb_dat_i[RXC_SIZE1_LSB +: RX_IDX_W];
                end
                OFS_FLAGS:
                begin
                    // Write one to clear; hardware sets below win
                    d.event_fifo_full_flag = q.event_fifo_full_flag & ~wdat[FLG_FULL_BIT];
                    d.event_fifo_lost_flag = q.event_fifo_lost_flag & ~wdat[FLG_LOST_BIT];
                    d.event_fifo_watermark_flag = q.event_fifo_watermark_flag & ~wdat[FLG_WM_BIT];
                end
                default:
                begin
                    if (wb_adr_i[8:7] == REGION_ID)
                        d.msg_id[wb_adr_i[6:2]] = wb_dat_i[28:0];
                    else if (wb_adr_i[8:7] == REGION_MARKER && wb_sel_i[0])
                        d.marker[wb_adr_i[6:2]] = wb_dat_i[7:0];
                end
            endcase
        end

        // Add and cancel requests
        d.tx_request_pending = q.tx_request_pending | add_bits;
        d.tx_occurred = q.tx_occurred & ~add_bits;
        d.tx_cancel_finished = q.tx_cancel_finished & ~add_bits;
        for (int i = 0; i < NBUF; i++)
        begin
            if (cancel_bits[i])
            begin
                if (q.tx_st == TX_BUSY && q.tx_buf == 5'(i))
                    d.cancel_armed = 1'b1;
                else if (q.tx_request_pending[i])
                begin
                    d.tx_request_pending[i] = 1'b0;
                    d.tx_cancel_finished[i] = 1'b1;
                end
            end
        end

        // Lowest identifier wins; equal identifiers go to the lowest buffer number
        best_found = 1'b0;
        best_idx = 5'h00;
        best_id = 29'h1fff_ffff;
        for (int i = 0; i < NBUF; i++)
        begin
            if (q.tx_request_pending[i] && !cancel_bits[i] && 7'(i) < active_total
                && (!best_found || q.msg_id[i] < best_id))
            begin
                best_found = 1'b1;
                best_idx = 5'(i);
                best_id = q.msg_id[i];
            end
        end

        // Second word of the previous event element
        if (q.ev_second)
        begin
            d.ev_second = 1'b0;
            d.ram_we = 1'b1;
            d.ram_addr = 16'(q.ram_addr + 16'h0001);
            d.ram_wdata = q.ev_word1;
        end

        unique case (q.tx_st)
            TX_IDLE:
            begin
                if (best_found)
                begin
                    d.tx_st = TX_BUSY;
                    d.tx_start = 1'b1;
                    d.tx_buf = best_idx;
                    d.tx_id = best_id;
                end
            end
            TX_BUSY:
            begin
                if (tx_done_i)
                begin
                    d.tx_st = TX_IDLE;
                    if (tx_ok_i)
                    begin
                        d.tx_request_pending[q.tx_buf] = 1'b0;
                        d.tx_occurred[q.tx_buf] = 1'b1;
                        if (d.cancel_armed || q.cancel_armed)
                            d.tx_cancel_finished[q.tx_buf] = 1'b1;
                        if (ev_depth != 6'h00)
                        begin
                            if (d.ev_fill >= ev_depth)
                                d.event_fifo_lost_flag = 1'b1;
                            else
                            begin
                                // Element sits at start plus twice the put index
                                d.ram_we = 1'b1;
                                d.ram_addr = 16'(q.event_fifo_start_address + {10'h0, d.ev_put, 1'b0});
                                d.ram_wdata = {3'h0, q.tx_id};
                                d.ev_word1 = {q.marker[q.tx_buf], 8'h00, timestamp_i};
                                d.ev_second = 1'b1;
                                d.ev_put = 5'(ring_next(7'(d.ev_put), 7'(ev_depth)));
                                d.ev_fill = 6'(d.ev_fill + 6'h01);
                                if (d.ev_fill == ev_depth)
                                    d.event_fifo_full_flag = 1'b1;
                                if (d.ev_fill == q.event_fifo_watermark_level)
                                    d.event_fifo_watermark_flag = 1'b1;
                            end
                        end
                    end
                    else if (d.cancel_armed || q.cancel_armed)
                    begin
                        // No retry after a cancel
                        d.tx_request_pending[q.tx_buf] = 1'b0;
                        d.tx_cancel_finished[q.tx_buf] = 1'b1;
                    end
                    // Cleared last so a cancel landing in the done cycle still counts
                    d.cancel_armed = 1'b0;
                end
            end
        endcase

        // Debug frame sequence; frames are ignored while locked
        unique case (q.debug_frame_state)
            DBG_IDLE:
            begin
                if (debug_frame_valid_i && debug_frame_sel_i == DBG_FRAME_A)
                    d.debug_frame_state = DBG_GOT_A;
            end
            DBG_GOT_A:
            begin
                if (debug_frame_valid_i)
                    d.debug_frame_state = (debug_frame_sel_i == DBG_FRAME_B) ? DBG_GOT_AB
                        : (debug_frame_sel_i == DBG_FRAME_A) ? DBG_GOT_A : DBG_IDLE;
            end
            DBG_GOT_AB:
            begin
                if (debug_frame_valid_i)
                begin
                    if (debug_frame_sel_i == DBG_FRAME_C)
                    begin
                        d.debug_frame_state = DBG_LOCKED;
                        d.dma_req = 1'b1;
                    end
                    else
                        d.debug_frame_state = (debug_frame_sel_i == DBG_FRAME_A) ? DBG_GOT_A : DBG_IDLE;
                end
            end
            DBG_LOCKED:
            begin
                if (dma_ack_i)
                begin
                    d.dma_req = 1'b0;
                    d.debug_frame_state = DBG_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
            q.tx_st <= TX_IDLE;
            q.debug_frame_state <= DBG_IDLE;
            q.dedicated_buffer_count <= RST_COUNT;
            q.queue_buffer_count <= RST_COUNT;
            q.event_fifo_start_address <= RST_EV_START;
        end
        else
            q <= d;
    end

    assign wb_dat_o = q.wb_dat;
    assign wb_ack_o = q.wb_ack;
    assign tx_start_o = q.tx_start;
    assign tx_buffer_o = q.tx_buf;
    assign tx_id_o = q.tx_id;
    assign ram_we_o = q.ram_we;
    assign ram_addr_o = q.ram_addr;
    assign ram_wdata_o = q.ram_wdata;
    assign dma_req_o = q.dma_req;
    assign debug_lock_o = q.dma_req;
endmodule // cte_top
`default_nettype wire

// [testbench/cte_checker.sv]
// Purpose: Port-level assertions for cte_top
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every cte_top instance
`timescale 1ns/10ps
`default_nettype none
module cte_checker
    import cte_pkg::*;
(
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Engine, message RAM and DMA
    input wire logic tx_start_o,
    input wire logic tx_done_i,
    input wire logic tx_ok_i,
    input wire logic ram_we_o,
    input wire logic [15:0] ram_addr_o,
    input wire logic debug_lock_o,
    input wire logic dma_req_o,
    input wire logic dma_ack_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_word0;
        $rose(ram_we_o);
    endsequence
    // Second word lands on the next address, then the write port goes quiet
    sequence s_word1;
        ram_we_o && ram_addr_o == $past(ram_addr_o) + 16'h1 ##1 !ram_we_o;
    endsequence
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data without ack");
    a_start_pulse: assert property (tx_start_o |=> !tx_start_o) else $error("start too long");
    a_ev_cause: assert property (s_word0 |-> $past(tx_done_i && tx_ok_i)) else $error("stray event");
    a_ev_pair: assert property (s_word0 |=> s_word1) else $error("event word pair");
    a_dma_hold: assert property (dma_req_o && !dma_ack_i |=> dma_req_o) else $error("dma req dropped");
    a_dma_clear: assert property (dma_req_o && dma_ack_i |=> !dma_req_o) else $error("dma req kept");
    a_lock_req: assert property (debug_lock_o == dma_req_o) else $error("lock differs");
endmodule // cte_checker
bind cte_top cte_checker u_cte_checker (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .tx_start_o,
    .tx_done_i, .tx_ok_i, .ram_we_o, .ram_addr_o, .debug_lock_o, .dma_req_o, .dma_ack_i);
`default_nettype wire

// [testbench/cte_far_model.sv]
// Purpose: Protocol engine and DMA controller standing beside cte_top
// Assumes: Frames last LEN cycles; DMA acknowledges after a fixed transfer time
// Notes:   Timestamp and ok wander outside their valid cycle to expose late sampling
`timescale 1ns/10ps
`default_nettype none
module cte_far_model #(parameter int LEN = 30)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Engine side
    input wire logic tx_start_o,
    input wire logic [4:0] tx_buffer_o,
    input wire logic ok_i,
    output logic tx_done_i,
    output logic tx_ok_i,
    output logic [15:0] timestamp_i,
    // DMA side
    input wire logic dma_req_o,
    output logic dma_ack_i
);
    logic [5:0] n_q;
    logic [4:0] d_q;
    logic [15:0] free_q;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            n_q <= 6'h00;
            d_q <= 5'h00;
            free_q <= 16'h0000;
            tx_done_i <= 1'b0;
            dma_ack_i <= 1'b0;
        end
        else
        begin
            free_q <= free_q + 16'h1;
            tx_done_i <= (n_q == 6'h01);
            n_q <= tx_start_o ? 6'(LEN) : (n_q != 6'h00 ? n_q - 6'h1 : n_q);
            // Acknowledge only once the transfer time has run out
            dma_ack_i <= dma_req_o && d_q == 5'h13;
            d_q <= dma_req_o ? d_q + 5'h1 : 5'h00;
        end
    end
    assign timestamp_i = (n_q != 6'h00 || tx_done_i) ? {8'ha5, 3'h0, tx_buffer_o} : free_q;
    assign tx_ok_i = tx_done_i ? ok_i : ~ok_i;
endmodule // cte_far_model
`default_nettype wire

// [testbench/tb.sv]
// Purpose: Self-checking bench for cte_top
// Assumes: Bench acts as Wishbone host and debug frame source
// Notes:   Scenarios run in order and share the arbitration set-up
`timescale 1ns/10ps
`default_nettype none
module tb;
    import cte_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, ok_i, dv, ack, start, done, tok, ram_we, lock, req, dack;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, dat_o, ram_wdata;
    logic [4:0] tbuf;
    logic [28:0] tid;
    logic [15:0] ts, ram_addr;
    logic [6:0] put0, put1;
    logic [1:0] dsel;
    int err_count = 0;
    int n_compared = 0;
    logic [4:0] starts[$];
    logic [47:0] evq[$];
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    cte_top u_cte_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .tx_start_o(start),
        .tx_buffer_o(tbuf), .tx_id_o(tid), .tx_done_i(done), .tx_ok_i(tok), .timestamp_i(ts), .ram_we_o(ram_we),
        .ram_addr_o(ram_addr), .ram_wdata_o(ram_wdata), .rx_fifo0_put_i(put0), .rx_fifo1_put_i(put1),
        .debug_frame_valid_i(dv), .debug_frame_sel_i(dsel), .debug_lock_o(lock), .dma_req_o(req), .dma_ack_i(dack));
    cte_far_model u_cte_far_model (.clk_i(clk_i), .rst_i(rst_i), .tx_start_o(start), .tx_buffer_o(tbuf),
        .ok_i(ok_i), .tx_done_i(done), .tx_ok_i(tok), .timestamp_i(ts), .dma_req_o(req), .dma_ack_i(dack));
    always @(posedge clk_i)
    begin
        if (start === 1'b1) starts.push_back(tbuf);
        if (ram_we === 1'b1) evq.push_back({ram_addr, ram_wdata});
    end
    task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task automatic rd(input logic [ADR_W-1:0] a, input logic [31:0] exp, input string nm);
        wb(1'b0, a, 32'h0);
        chk(nm, 48'(rdat), 48'(exp));
    endtask
    // Bounded wait for a register value; the caller judges the last read
    task automatic poll(input logic [ADR_W-1:0] a, input logic [31:0] exp);
        for (int i = 0; i < 300; i++)
        begin
            wb(1'b0, a, 32'h0);
            if (rdat === exp) break;
        end
    endtask
    task automatic frame(input logic [1:0] s);
        @(posedge clk_i);
        dv <= 1'b1; dsel <= s;
        @(posedge clk_i);
        dv <= 1'b0;
    endtask
    task automatic t_reset;
        rd(OFS_DEBUG_STATUS, 32'h0, "debug state");
        wb(1'b1, 9'h03c, 32'hffff_ffff);
        rd(9'h03c, 32'h0, "unmapped");
    endtask
    task automatic t_prio;
        logic [28:0] ids[5] = '{29'h300, 29'h100, 29'h200, 29'h400, 29'h050};
        logic [7:0] mk[5] = '{8'h33, 8'h11, 8'h22, 8'h44, 8'h55};
        logic [47:0] ev[4] = '{{16'h40, 32'h100}, {16'h41, 32'h1100_a501}, {16'h42, 32'h200}, {16'h43, 32'h2200_a502}};
        logic [4:0] ord[3] = '{5'h1, 5'h2, 5'h0};
        wb(1'b1, OFS_BUF_CONFIG, 32'h0000_0202);
        wb(1'b1, OFS_EV_CONFIG, 32'h0102_0040);
        for (int i = 0; i < 5; i++)
        begin
            wb(1'b1, 9'h080 + 9'(4 * i), {3'h0, ids[i]});
            wb(1'b1, 9'h100 + 9'(4 * i), {24'h0, mk[i]});
        end
        wb(1'b1, OFS_ADD_REQUEST, 32'h0000_0017);
        poll(OFS_OCCURRED, 32'h7);
        chk("occurred", 48'(rdat), 48'h7);
        chk("tx id", 48'(tid), 48'h300);
        chk("start count", 48'(starts.size()), 48'h3);
        for (int i = 0; i < 3; i++) chk("tx order", 48'(starts[i]), 48'(ord[i]));
        chk("event count", 48'(evq.size()), 48'h4);
        for (int i = 0; i < 4; i++) chk("event word", evq[i], ev[i]);
        rd(OFS_FLAGS, 32'h7, "flags");
        rd(OFS_EV_STATUS, 32'h0100_0002, "event status");
        rd(OFS_REQUEST_PENDING, 32'h10, "pending");
    endtask
    task automatic t_ack;
        wb(1'b1, OFS_EV_ACK, 32'h0);
        rd(OFS_EV_STATUS, 32'h0000_0101, "event status");
        wb(1'b1, OFS_RX_CONFIG, 32'h0000_0810);
        wb(1'b1, OFS_RX0_ACK, 32'h2);
        wb(1'b1, OFS_RX1_ACK, 32'h1);
        rd(OFS_RX_STATUS, 32'h0402_0203, "rx status");
        wb(1'b1, OFS_FLAGS, 32'h7);
        rd(OFS_FLAGS, 32'h0, "flags cleared");
    endtask
    task automatic t_cancel;
        int n0;
        wb(1'b1, OFS_CANCEL_REQUEST, 32'h10);
        rd(OFS_REQUEST_PENDING, 32'h0, "pending");
        rd(OFS_CANCEL_FINISHED, 32'h10, "cancel finished");
        for (int k = 0; k < 2; k++)
        begin
            ok_i <= k[0];
            n0 = starts.size();
            wb(1'b1, OFS_ADD_REQUEST, 32'h1);
            wb(1'b1, OFS_CANCEL_REQUEST, 32'h1);
            rd(OFS_REQUEST_PENDING, 32'h1, "pending busy");
            poll(OFS_REQUEST_PENDING, 32'h0);
            rd(OFS_OCCURRED, k ? 32'h7 : 32'h6, "occurred");
            rd(OFS_CANCEL_FINISHED, 32'h11, "cancel finished");
            chk("no retry", 48'(starts.size() - n0), 48'h1);
        end
    endtask
    task automatic t_dma;
        frame(2'h1); frame(2'h3); frame(2'h1); frame(2'h2);
        rd(OFS_DEBUG_STATUS, 32'h2, "debug order");
        frame(2'h3);
        rd(OFS_DEBUG_STATUS, 32'h7, "dma request");
        chk("lock", 48'(lock), 48'h1);
        frame(2'h1);
        rd(OFS_DEBUG_STATUS, 32'h7, "locked");
        poll(OFS_DEBUG_STATUS, 32'h0);
        chk("dma done", 48'(rdat), 48'h0);
    endtask
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Whole run needs a few hundred cycles
    initial
    begin
        #2000000;
        err_count++;
        close_out();
    end
    initial
    begin
        rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; sel = 4'hf; wdat = 32'h0;
        ok_i = 1'b1; dv = 1'b0; dsel = 2'h0; put0 = 7'h05; put1 = 7'h06;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset(); t_prio(); t_ack(); t_cancel(); t_dma();
        close_out();
    end
endmodule // tb
`default_nettype wire
